// >>> inc/ccf_pkg.sv
// ccf_pkg: frame layout, command codes and timing tables for channel setup frames
package ccf_pkg;
  // ***************************************************************
  // frame layout
  // ***************************************************************
  localparam int         FRAME_W   = 32;
  localparam int         CMD_HI    = 31;
  localparam int         CMD_LO    = 28;
  localparam int         RW_BIT    = 27;
  localparam int         EXT_HI    = 26;
  localparam int         EXT_LO    = 24;
  localparam int         CFG_HI    = 23;
  localparam int         CFG_LO    = 1;
  localparam int         PAR_BIT   = 0;
  localparam logic [3:0] CMD_CH1   = 4'h1;
  localparam logic [3:0] CMD_CH2   = 4'h2;
  localparam logic [5:0] CNT_FULL  = 6'h20;
  localparam logic [22:0] CFG_RESET = 23'h00_0000;
  localparam logic [2:0] EXT_RESET = 3'h0;
  // ***************************************************************
  // timing tables, ns, at 125 MHz; SCLK_HALF in clock cycles
  // ***************************************************************
  localparam int CLK_NS        = 8;
  localparam int DEAD_NS[4]    = '{1000, 2000, 4000, 8000};
  localparam int OFF_NS[4]     = '{31000, 48000, 62500, 125000};
  localparam int DIAG_HB_NS[4] = '{11200, 28900, 40000, 51200};
  localparam int DIAG_NS[4]    = '{25600, 61200, 105600, 150000};
  localparam int BLANK_NS[8]   = '{11100, 15600, 20000, 31100, 42200, 53300, 97800, 142200};
  localparam int SCLK_HALF     = 12;
  // ***************************************************************
  // host register map
  // ***************************************************************
  localparam logic [3:0] WB_TX_ADDR   = 4'h0;
  localparam logic [3:0] WB_STAT_ADDR = 4'h4;
  localparam logic [3:0] WB_RX_ADDR   = 4'h8;
  localparam int         STAT_BUSY    = 0;
  localparam int         STAT_PAR_OK  = 1;
  localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;

  typedef struct packed {
    logic [1:0] diag_filter;
    logic       overcurrent_threshold_report_select;
    logic [5:0] overcurrent_threshold_code;
    logic [1:0] overcurrent_temperature_compensation;
    logic       overcurrent_battery_compensation;
    logic [2:0] overcurrent_blanking_time;
    logic       reengage_strategy;
    logic       overcurrent_sense_method;
    logic       open_load_current;
    logic [1:0] gate_current_select;
    logic       p_channel;
    logic       channel_topology_select;
    logic       output_enable;
  } ccf_chan_cfg_s;

  function automatic logic [15:0] ns_to_cyc(input int ns);
    return 16'((ns + CLK_NS - 1) / CLK_NS);
  endfunction

  function automatic logic parity_bit(input logic [30:0] b);
    return ~^b;
  endfunction
endpackage

// >>> inc/ccf_link_if.sv
// ccf_link_if: serial frame link between host controller and channel setup device
`timescale 1ns/10ps
interface ccf_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport dev  (input sclk, input cs_n, input mosi, output miso);
  modport host (output sclk, output cs_n, output mosi, input miso);
endinterface

// >>> rtl/ccf_device.sv
// ccf_device: channel 1/2 setup frames, decode, storage and readback
//
// Local design decisions: register access over Wishbone and the address map.
`timescale 1ns/10ps
module ccf_device
  import ccf_pkg::*;
(
  // clock and reset
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_srst,
  // link
  ccf_link_if.dev                     link,
  // system inputs
  input  wire logic                   i_bridge1_grouping_enable,
  input  wire logic [5:0]             i_ch1_actual_threshold,
  input  wire logic [5:0]             i_ch2_actual_threshold,
  // stored fields
  output ccf_pkg::ccf_chan_cfg_s      o_ch1_cfg,
  output ccf_pkg::ccf_chan_cfg_s      o_ch2_cfg,
  output logic [1:0]                  o_bridge1_crossover_guard,
  output logic                        o_bridge1_diag_timer_sharing,
  output logic [1:0]                  o_bridge1_limit_off_interval,
  output logic                        o_battery_comp_factor_select,
  // effective timing
  output logic [15:0]                 o_dead_cycles,
  output logic [15:0]                 o_off_cycles,
  output logic [15:0]                 o_ch1_diag_cycles,
  output logic [15:0]                 o_ch2_diag_cycles,
  output logic [15:0]                 o_ch1_blank_cycles,
  output logic [15:0]                 o_ch2_blank_cycles,
  output logic                        o_ch1_reengage_after_readout,
  output logic                        o_ch2_reengage_after_readout,
  // frame events
  output logic                        o_frame_done,
  output logic                        o_frame_error
);
  import ccf_pkg::*;

  // ***************************************************************
  // pin synchronisers
  // ***************************************************************
  logic [2:0] sclk_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [2:0] mosi_sync_reg;
  logic       sclk_lvl_reg;
  logic       cs_lvl_reg;
  logic       mosi_lvl_reg;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 3'h7;
      mosi_sync_reg <= 3'h0;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], link.sclk};
      cs_sync_reg   <= {cs_sync_reg[1:0], link.cs_n};
      mosi_sync_reg <= {mosi_sync_reg[1:0], link.mosi};
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      sclk_lvl_reg <= 1'b0;
      cs_lvl_reg   <= 1'b1;
      mosi_lvl_reg <= 1'b0;
    end
    else
    begin
      if (sclk_sync_reg[2] == sclk_sync_reg[1])
        sclk_lvl_reg <= sclk_sync_reg[2];
      if (cs_sync_reg[2] == cs_sync_reg[1])
        cs_lvl_reg <= cs_sync_reg[2];
      if (mosi_sync_reg[2] == mosi_sync_reg[1])
        mosi_lvl_reg <= mosi_sync_reg[2];
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_fall;
  logic cs_rise;
  always_comb
  begin
    sclk_rise = !cs_lvl_reg && (sclk_sync_reg[2] == sclk_sync_reg[1]) && sclk_sync_reg[2] && !sclk_lvl_reg;
    sclk_fall = !cs_lvl_reg && (sclk_sync_reg[2] == sclk_sync_reg[1]) && !sclk_sync_reg[2] && sclk_lvl_reg;
    cs_fall   = (cs_sync_reg[2] == cs_sync_reg[1]) && !cs_sync_reg[2] && cs_lvl_reg;
    cs_rise   = (cs_sync_reg[2] == cs_sync_reg[1]) && cs_sync_reg[2] && !cs_lvl_reg;
  end

  // ***************************************************************
  // shifters
  // ***************************************************************
  logic [31:0] rx_reg;
  logic [31:0] tx_reg;
  logic [31:0] resp_reg;
  logic [5:0]  cnt_reg;
  logic        miso_reg;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      rx_reg   <= WORD_ZERO;
      tx_reg   <= WORD_ZERO;
      cnt_reg  <= 6'h00;
      miso_reg <= 1'b0;
    end
    else if (cs_fall)
    begin
      cnt_reg  <= 6'h00;
      tx_reg   <= {resp_reg[30:0], 1'b0};
      miso_reg <= resp_reg[31];
    end
    else if (sclk_rise)
    begin
      rx_reg  <= {rx_reg[30:0], mosi_lvl_reg};
      if (cnt_reg != CNT_FULL + 6'h01)
        cnt_reg <= cnt_reg + 6'h01;
    end
    else if (sclk_fall)
    begin
      miso_reg <= tx_reg[31];
      tx_reg   <= {tx_reg[30:0], 1'b0};
    end
  end

  assign link.miso = miso_reg;

  // ***************************************************************
  // frame decode
  // ***************************************************************
  logic       frame_ok;
  logic [3:0] cmd;
  always_comb
  begin
    cmd = rx_reg[CMD_HI:CMD_LO];
    frame_ok = cs_rise && (cnt_reg == CNT_FULL) && (rx_reg[PAR_BIT] == parity_bit(rx_reg[31:1]));
  end

  ccf_chan_cfg_s ch1_reg;
  ccf_chan_cfg_s ch2_reg;
  logic [2:0]    ext1_reg;
  logic [2:0]    ext2_reg;
  logic          resp_pend_reg;
  logic [3:0]    resp_cmd_reg;

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      ch1_reg  <= ccf_chan_cfg_s'(CFG_RESET);
      ch2_reg  <= ccf_chan_cfg_s'(CFG_RESET);
      ext1_reg <= EXT_RESET;
      ext2_reg <= EXT_RESET;
    end
    // write only when bit 27 low
    else if (frame_ok && !rx_reg[RW_BIT])
    begin
      if (cmd == CMD_CH1)
      begin
        ch1_reg  <= ccf_chan_cfg_s'(rx_reg[CFG_HI:CFG_LO]);
        ext1_reg <= rx_reg[EXT_HI:EXT_LO];
      end
      else if (cmd == CMD_CH2)
      begin
        ch2_reg  <= ccf_chan_cfg_s'(rx_reg[CFG_HI:CFG_LO]);
        ext2_reg <= rx_reg[EXT_HI:EXT_LO];
      end
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      resp_pend_reg <= 1'b0;
      resp_cmd_reg  <= 4'h0;
      o_frame_done  <= 1'b0;
      o_frame_error <= 1'b0;
    end
    else
    begin
      resp_pend_reg <= cs_rise;
      resp_cmd_reg  <= frame_ok ? cmd : 4'h0;
      o_frame_done  <= frame_ok;
      o_frame_error <= cs_rise && !frame_ok;
    end
  end

  // ***************************************************************
  // readback
  // ***************************************************************
  function automatic logic [31:0] build_resp(input logic [3:0] c, input logic [2:0] ext,
                                             input ccf_chan_cfg_s cfg, input logic [5:0] act);
    ccf_chan_cfg_s r;
    logic [30:0]   b;
    r = cfg;
    if (cfg.overcurrent_threshold_report_select)
      r.overcurrent_threshold_code = act;
    b = {c, 1'b0, ext, r};
    return {b, parity_bit(b)};
  endfunction

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
      resp_reg <= {31'h0000_0000, 1'b1};
    else if (resp_pend_reg)
    begin
      if (resp_cmd_reg == CMD_CH1)
        resp_reg <= build_resp(CMD_CH1, ext1_reg, ch1_reg, i_ch1_actual_threshold);
      else if (resp_cmd_reg == CMD_CH2)
        resp_reg <= build_resp(CMD_CH2, ext2_reg, ch2_reg, i_ch2_actual_threshold);
      else
        resp_reg <= {31'h0000_0000, 1'b1};
    end
  end

  // ***************************************************************
  // effective settings
  // ***************************************************************
  logic hb_shared;
  always_comb
  begin
    // shared diag timing only with bridge grouping and sharing bit (ext1_reg[0]) low
    hb_shared = i_bridge1_grouping_enable && !ext1_reg[0];
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_dead_cycles                <= 16'h0000;
      o_off_cycles                 <= 16'h0000;
      o_ch1_diag_cycles            <= 16'h0000;
      o_ch2_diag_cycles            <= 16'h0000;
      o_ch1_blank_cycles           <= 16'h0000;
      o_ch2_blank_cycles           <= 16'h0000;
      o_ch1_reengage_after_readout <= 1'b0;
      o_ch2_reengage_after_readout <= 1'b0;
    end
    else
    begin
      o_dead_cycles <= ns_to_cyc(DEAD_NS[ext1_reg[2:1]]);
      o_off_cycles  <= ns_to_cyc(OFF_NS[ext2_reg[2:1]]);
      if (hb_shared)
        o_ch1_diag_cycles <= ns_to_cyc(DIAG_HB_NS[ch1_reg.diag_filter]);
      else
        o_ch1_diag_cycles <= ns_to_cyc(DIAG_NS[ch1_reg.diag_filter]);
      if (hb_shared)
        o_ch2_diag_cycles <= ns_to_cyc(DIAG_HB_NS[ch1_reg.diag_filter]);
      else
        o_ch2_diag_cycles <= ns_to_cyc(DIAG_NS[ch2_reg.diag_filter]);
      o_ch1_blank_cycles <= ns_to_cyc(BLANK_NS[ch1_reg.overcurrent_blanking_time]);
      o_ch2_blank_cycles <= ns_to_cyc(BLANK_NS[ch2_reg.overcurrent_blanking_time]);
      o_ch1_reengage_after_readout <= ch1_reg.reengage_strategy || i_bridge1_grouping_enable;
      o_ch2_reengage_after_readout <= ch2_reg.reengage_strategy || i_bridge1_grouping_enable;
    end
  end

  // ***************************************************************
  // stored field outputs
  // ***************************************************************
  always_comb
  begin
    o_ch1_cfg                    = ch1_reg;
    o_ch2_cfg                    = ch2_reg;
    o_bridge1_crossover_guard    = ext1_reg[2:1];
    o_bridge1_diag_timer_sharing = ext1_reg[0];
    o_bridge1_limit_off_interval = ext2_reg[2:1];
    o_battery_comp_factor_select = ext2_reg[0];
  end
endmodule

// >>> rtl/ccf_host.sv
// ccf_host: frame master with classic Wishbone register port
`timescale 1ns/10ps
module ccf_host
  import ccf_pkg::*;
#(
  parameter int HALF = ccf_pkg::SCLK_HALF
)
(
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_srst,
  // wishbone slave
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [3:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic [31:0]      o_wb_dat,
  output logic             o_wb_ack,
  // link
  ccf_link_if.host         link
);
  import ccf_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LEAD = 2'b01,
    ST_SHIFT = 2'b10,
    ST_TAIL = 2'b11
  } ccf_state_e;

  // ***************************************************************
  // register port
  // ***************************************************************
  ccf_state_e  st_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic        req;
  logic        start;
  logic [2:0]  miso_sync_reg;
  logic        miso_lvl_reg;

  always_comb
  begin
    req   = i_wb_cyc && i_wb_stb && !o_wb_ack;
    start = req && i_wb_we && (i_wb_adr == WB_TX_ADDR) && (i_wb_sel == 4'hf) && (st_reg == ST_IDLE);
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= WORD_ZERO;
    end
    else
    begin
      o_wb_ack <= req;
      o_wb_dat <= WORD_ZERO;
      if (req && !i_wb_we)
      begin
        case (i_wb_adr)
          WB_TX_ADDR:   o_wb_dat <= tx_reg;
          WB_STAT_ADDR: o_wb_dat <= {30'h0000_0000,
                                     rx_reg[PAR_BIT] == parity_bit(rx_reg[31:1]),
                                     st_reg != ST_IDLE};
          WB_RX_ADDR:   o_wb_dat <= rx_reg;
          default:      o_wb_dat <= WORD_ZERO;
        endcase
      end
    end
  end

  // ***************************************************************
  // clock divider and shifter
  // ***************************************************************
  logic [7:0] div_reg;
  logic [5:0] bit_reg;
  logic       sclk_reg;
  logic       cs_n_reg;
  logic       tick;
  assign tick = (div_reg == 8'(HALF - 1));

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      miso_sync_reg <= 3'h0;
      miso_lvl_reg  <= 1'b0;
    end
    else
    begin
      miso_sync_reg <= {miso_sync_reg[1:0], link.miso};
      if (miso_sync_reg[2] == miso_sync_reg[1])
        miso_lvl_reg <= miso_sync_reg[2];
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_srst)
    begin
      st_reg   <= ST_IDLE;
      div_reg  <= 8'h00;
      bit_reg  <= 6'h00;
      sclk_reg <= 1'b0;
      cs_n_reg <= 1'b1;
      tx_reg   <= WORD_ZERO;
      rx_reg   <= WORD_ZERO;
    end
    else
    begin
      div_reg <= (tick || st_reg == ST_IDLE) ? 8'h00 : div_reg + 8'h01;
      case (st_reg)
        ST_IDLE:
        begin
          if (start)
          begin
            tx_reg   <= {i_wb_dat[31:1], parity_bit(i_wb_dat[31:1])};
            cs_n_reg <= 1'b0;
            bit_reg  <= 6'h00;
            st_reg   <= ST_LEAD;
          end
        end
        ST_LEAD:
        begin
          if (tick)
          begin
            sclk_reg <= 1'b1;
            rx_reg   <= {rx_reg[30:0], miso_lvl_reg};
            st_reg   <= ST_SHIFT;
          end
        end
        ST_SHIFT:
        begin
          if (tick)
          begin
            sclk_reg <= !sclk_reg;
            if (sclk_reg)
            begin
              bit_reg <= bit_reg + 6'h01;
              if (bit_reg == CNT_FULL - 6'h01)
                st_reg <= ST_TAIL;
              else
                tx_reg <= {tx_reg[30:0], 1'b0};
            end
            else
              rx_reg <= {rx_reg[30:0], miso_lvl_reg};
          end
        end
        ST_TAIL:
        begin
          if (tick)
          begin
            cs_n_reg <= 1'b1;
            st_reg   <= ST_IDLE;
          end
        end
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_reg;
  assign link.cs_n = cs_n_reg;
  assign link.mosi = tx_reg[31];
endmodule

// >>> sim/ccf_link_chk.sv
// ccf_link_chk: link protocol assertions between host and device
`timescale 1ns/10ps
module ccf_link_chk
  import ccf_pkg::*;
#(
  parameter int HALF = 12
)
(
  // clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_srst,
  // link
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  input  wire logic miso
);
  logic [5:0]  cnt_reg;
  logic [7:0]  run_reg;
  logic [31:0] tx_reg;
  logic [31:0] rx_reg;
  logic [31:0] ptx_reg;
  logic        pok_reg;

  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);

  // ***************************************************************
  // helper logic
  // ***************************************************************
  always_ff @(posedge i_clk_sys)
    if (i_srst || $fell(cs_n))
      cnt_reg <= 6'h00;
    else if ($rose(sclk))
      cnt_reg <= cnt_reg + 6'h01;

  always_ff @(posedge i_clk_sys)
    if (i_srst || $changed(sclk) || $changed(cs_n))
      run_reg <= 8'h00;
    else if (run_reg != 8'hff)
      run_reg <= run_reg + 8'h01;

  always_ff @(posedge i_clk_sys)
    if ($rose(sclk))
    begin
      tx_reg <= {tx_reg[30:0], mosi};
      rx_reg <= {rx_reg[30:0], miso};
    end

  always_ff @(posedge i_clk_sys)
    if (i_srst)
      pok_reg <= 1'b0;
    else if ($rose(cs_n))
    begin
      ptx_reg <= tx_reg;
      pok_reg <= (tx_reg[31:28] == CMD_CH1) || (tx_reg[31:28] == CMD_CH2);
    end

  // ***************************************************************
  // assertions
  // ***************************************************************
  AST_SCLK_IDLE: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside frame");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> cnt_reg == CNT_FULL)
    else $error("frame without 32 clock rises");
  AST_HALF_TIME: assert property ($changed(sclk) |-> run_reg == 8'(HALF - 1))
    else $error("serial clock half period wrong");
  AST_MOSI_HOLD: assert property (sclk |-> $stable(mosi))
    else $error("mosi moved while clock high");
  AST_TX_PAR: assert property ($rose(cs_n) |-> (^tx_reg) == 1'b1)
    else $error("host frame parity wrong");
  AST_RX_PAR: assert property ($rose(cs_n) |-> (^rx_reg) == 1'b1)
    else $error("device response parity wrong");
  AST_RX_NULL: assert property ($rose(cs_n) && !pok_reg |-> rx_reg == 32'h0000_0001)
    else $error("null response expected");
  AST_RX_CMD: assert property ($rose(cs_n) && pok_reg |-> rx_reg[31:27] == {ptx_reg[31:28], 1'b0})
    else $error("response command field wrong");
  AST_RX_ECHO: assert property ($rose(cs_n) && pok_reg && !ptx_reg[27] && !ptx_reg[21]
    |-> rx_reg[26:1] == ptx_reg[26:1])
    else $error("response fields differ from written");
endmodule

// >>> sim/testbench.sv
// testbench: host and device joined over the link, driven through wishbone
`timescale 1ns/10ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module testbench;
  import ccf_pkg::*;
  localparam int         HALF_SET = 10;
  localparam logic [5:0] ACT1     = 6'h3b;
  logic          i_clk_sys;
  logic          i_srst;
  logic          wb_cyc;
  logic          wb_stb;
  logic          wb_we;
  logic [3:0]    wb_adr;
  logic [3:0]    wb_sel;
  logic [31:0]   wb_dat;
  logic [31:0]   rdat;
  logic          wb_ack;
  logic          grp;
  ccf_chan_cfg_s ch1_cfg;
  ccf_chan_cfg_s ch2_cfg;
  logic [1:0]    guard;
  logic [1:0]    offv;
  logic          share;
  logic          bfact;
  logic [15:0]   dead;
  logic [15:0]   off;
  logic [15:0]   d1;
  logic [15:0]   d2;
  logic [15:0]   b1;
  logic [15:0]   b2;
  logic          re1;
  logic          re2;
  logic          done;
  logic          ferr;
  int            compares;
  int            n_mismatch;

  ccf_link_if link ();

  ccf_host #(.HALF(HALF_SET)) ccf_host_inst
  (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .i_wb_cyc  (wb_cyc),
    .i_wb_stb  (wb_stb),
    .i_wb_we   (wb_we),
    .i_wb_adr  (wb_adr),
    .i_wb_sel  (wb_sel),
    .i_wb_dat  (wb_dat),
    .o_wb_dat  (rdat),
    .o_wb_ack  (wb_ack),
    .link      (link)
  );

  ccf_device ccf_device_inst
  (
    .i_clk_sys                    (i_clk_sys),
    .i_srst                       (i_srst),
    .link                         (link),
    .i_bridge1_grouping_enable    (grp),
    .i_ch1_actual_threshold       (ACT1),
    .i_ch2_actual_threshold       (6'h15),
    .o_ch1_cfg                    (ch1_cfg),
    .o_ch2_cfg                    (ch2_cfg),
    .o_bridge1_crossover_guard    (guard),
    .o_bridge1_diag_timer_sharing (share),
    .o_bridge1_limit_off_interval (offv),
    .o_battery_comp_factor_select (bfact),
    .o_dead_cycles                (dead),
    .o_off_cycles                 (off),
    .o_ch1_diag_cycles            (d1),
    .o_ch2_diag_cycles            (d2),
    .o_ch1_blank_cycles           (b1),
    .o_ch2_blank_cycles           (b2),
    .o_ch1_reengage_after_readout (re1),
    .o_ch2_reengage_after_readout (re2),
    .o_frame_done                 (done),
    .o_frame_error                (ferr)
  );

  ccf_link_chk #(.HALF(HALF_SET)) ccf_link_chk_inst
  (
    .i_clk_sys (i_clk_sys),
    .i_srst    (i_srst),
    .sclk      (link.sclk),
    .cs_n      (link.cs_n),
    .mosi      (link.mosi),
    .miso      (link.miso)
  );

  // ***************************************************************
  // helpers
  // ***************************************************************
  function automatic logic [15:0] c8(input int ns);
    return 16'((ns + 7) / 8);
  endfunction

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    @(posedge i_clk_sys);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= w;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_dat <= d;
    k = 0;
    do
    begin
      @(posedge i_clk_sys);
      k++;
    end while (wb_ack !== 1'b1 && k < 50);
    q = rdat;
    `CHK(wb_ack, 1'b1)
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
    wb_sel <= 4'h0;
    @(posedge i_clk_sys);
  endtask

  task automatic frm(input logic [31:0] f);
    logic [31:0] q;
    int          k;
    wb(1'b1, WB_TX_ADDR, f, q);
    k = 0;
    do
    begin
      @(posedge i_clk_sys);
      k++;
    end while (done !== 1'b1 && ferr !== 1'b1 && k < 2000);
    `CHK({done, ferr}, 2'b10)
    repeat (3) @(posedge i_clk_sys);
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic t_reset();
    logic [31:0] q;
    `CHK({ch1_cfg, ch2_cfg}, {CFG_RESET, CFG_RESET})
    `CHK({guard, share, dead}, 19'h0_0000)
    wb(1'b0, 4'hc, WORD_ZERO, q);
    `CHK(q, WORD_ZERO)
  endtask

  task automatic t_ch1();
    ccf_chan_cfg_s c;
    logic [1:0]    k;
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      c = 23'h2A_AAAA ^ {23{k[0]}};
      c.diag_filter = k;
      c.overcurrent_blanking_time = {1'b0, k};
      grp <= k[1];
      frm({CMD_CH1, 1'b0, k, k[0], c, 1'b0});
      `CHK(ch1_cfg, c)
      `CHK({guard, share}, {k, k[0]})
      `CHK(dead, c8(DEAD_NS[i]))
      `CHK(b1, c8(BLANK_NS[i]))
      `CHK(d1, c8((k == 2'h2) ? DIAG_HB_NS[i] : DIAG_NS[i]))
      `CHK(re1, c.reengage_strategy | k[1])
    end
  endtask

  task automatic t_ch2();
    ccf_chan_cfg_s c;
    logic [1:0]    k;
    c = CFG_RESET;
    c.diag_filter = 2'h1;
    frm({CMD_CH1, 1'b0, 3'h0, c, 1'b0});
    for (int i = 0; i < 4; i++)
    begin
      k = 2'(i);
      c = 23'h55_5555 ^ {23{k[1]}};
      c.diag_filter = ~k;
      c.overcurrent_blanking_time = {1'b1, k};
      grp <= k[0];
      frm({CMD_CH2, 1'b0, k, k[0], c, 1'b0});
      `CHK(ch2_cfg, c)
      `CHK({offv, bfact}, {k, k[0]})
      `CHK(off, c8(OFF_NS[i]))
      `CHK(b2, c8(BLANK_NS[i + 4]))
      `CHK(d2, c8(k[0] ? DIAG_HB_NS[1] : DIAG_NS[3 - i]))
      `CHK(d1, c8(k[0] ? DIAG_HB_NS[1] : DIAG_NS[1]))
      `CHK(re2, c.reengage_strategy | k[0])
    end
  endtask

  task automatic t_ro();
    ccf_chan_cfg_s c;
    logic [31:0]   q;
    c = 23'h12_3456;
    frm({CMD_CH1, 1'b0, 3'h5, c, 1'b0});
    frm({4'h3, 1'b0, 26'h3FF_FFFF, 1'b0});
    `CHK(ch1_cfg, c)
    wb(1'b0, WB_RX_ADDR, WORD_ZERO, q);
    `CHK(q[31:27], {CMD_CH1, 1'b0})
    `CHK(q[21:15], {1'b1, ACT1})
    `CHK(q[14:1], c[13:0])
    frm({CMD_CH1, 1'b1, 3'h2, ~c, 1'b0});
    `CHK({ch1_cfg, guard}, {c, 2'h2})
    wb(1'b0, WB_RX_ADDR, WORD_ZERO, q);
    `CHK(q, 32'h0000_0001)
    wb(1'b0, WB_STAT_ADDR, WORD_ZERO, q);
    `CHK(q[1:0], 2'h2)
    frm({4'h3, 1'b0, 26'h000_0000, 1'b0});
    wb(1'b0, WB_RX_ADDR, WORD_ZERO, q);
    `CHK(q[31:22], {CMD_CH1, 1'b0, 3'h5, c.diag_filter})
  endtask

  task automatic print_verdict();
    $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ***************************************************************
  // clock, sequence and watchdog
  // ***************************************************************
  initial
  begin
    i_clk_sys = 1'b0;
    forever #4 i_clk_sys = ~i_clk_sys;
  end

  initial
  begin
    i_srst = 1'b1;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 4'h0;
    wb_sel = 4'h0;
    wb_dat = WORD_ZERO;
    grp = 1'b0;
    compares = 0;
    n_mismatch = 0;
    repeat (5) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    t_reset();
    t_ch1();
    t_ch2();
    t_ro();
    print_verdict();
  end

  initial
  begin
    repeat (40000) @(posedge i_clk_sys);
    n_mismatch++;
    print_verdict();
  end
endmodule
